// [hw/psdc_consts.svh]
`ifndef PSDC_CONSTS_SVH
`define PSDC_CONSTS_SVH

// Monitor register field positions.
`define PSDC_MON_NORMAL_BIT   7
`define PSDC_MON_LOWER_BIT    6
`define PSDC_MON_LATCH_BIT    5
`define PSDC_MON_CFG_RESET    3'h7

// Frame receiver.
`define PSDC_FRAME_BITS       16
`define PSDC_FRAME_CNT_W      5
`define PSDC_HOLD_RESET       16'hFFFF
`define PSDC_HOLD_TEST_BIT    8

// Stage numbering: index 0 is stage 1, index 7 is stage 8.
`define PSDC_STAGE8_IDX       7
`define PSDC_ALL_SERIAL       16'hFFFF
`define PSDC_ALL_OFF          16'h0000

// Supply filter time before the enable pin is released.
`define PSDC_CLK_MHZ          100
`define PSDC_FILTER_NS        10000
`define PSDC_FILTER_CYC       ((`PSDC_FILTER_NS * `PSDC_CLK_MHZ) / 1000)
`define PSDC_FILT_W           12

`endif

// [hw/psdc_pkg.sv]
package psdc_pkg;
  typedef enum logic [1:0] {PSDC_SRC_PAR, PSDC_SRC_SPI, PSDC_SRC_UBUS} psdc_src_t;
  typedef enum logic [1:0] {PSDC_MON_OK, PSDC_MON_FAULT, PSDC_MON_FILTER} psdc_mon_state_t;
endpackage

// [hw/psdc_top.sv]
// Contract
// - Reset low switches off stages 1-7, 9-16.
// - After reset, stages follow SPI control.
// - Stage 8 on pin ignores reset above 3.5V.
// - Stage 8 never driven from serial bus.
// - Multiplex bit 0 plus serial select: bus.
// - Frame clock accepted from zero to 16 MHz.
// - Sync rising edge loads 16-bit holding register.
// - Holding bits map to stages per table.
// - Bit 0 on, 1 off; resets all ones.
// - Holding bit 8 is readable test bit.
// - Unused pins readable while bus drives stages.
// - Supply out of window pulls enable low.
// - Pin-driven stage 8 off only below 3.5V or on overvoltage.
// - Supply fault or external low disables stages.
// - Undervoltage recovery releases after filter time.
// - Overvoltage recovery waits filter time, after latch clear if latched.
// - Supply or enable shutdown stores no fault.
// - Bit 2 enable level, bit 1 no undervoltage.
// - Bit 0 low during or latched overvoltage.
// - Pattern 000 lowers upper threshold for test.
// - Pattern 010 lifts lower threshold for test.
// - Latch clear works even while overvoltage lasts.
// - Stored overvoltage survives the external reset.
`include "psdc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module psdc_top
  import psdc_pkg::*;
(
  input  wire logic        mclk_i,             // Device clock, 100 MHz.
  input  wire logic        rst_b_i,            // External reset pin, active low.
  input  wire logic        por_b_i,            // Internal undervoltage reset, active low.
  input  wire logic        frame_clock_in_i,   // Serial bus clock.
  input  wire logic        frame_data_in_i,    // Serial bus data.
  input  wire logic        frame_sync_strobe_i, // Serial bus sync.
  input  wire logic [15:0] par_in_i,           // Parallel input pins, bit 0 is stage 1.
  input  wire logic [15:0] spi_stage_on_i,     // SPI stage control, 1 is on.
  input  wire logic [15:0] source_select_regs_i, // 1 selects serial access.
  input  wire logic        bus_multiplex_select_i, // 0 selects the serial bus.
  input  wire logic        mon_wr_i,           // Monitor register write strobe.
  input  wire logic [7:0]  mon_wdata_i,        // Monitor register write data.
  input  wire logic        vdd_ov_i,           // Comparator: above upper threshold.
  input  wire logic        vdd_ov_test_i,      // Comparator: above lowered upper threshold.
  input  wire logic        vdd_uv_i,           // Comparator: below lower threshold.
  input  wire logic        vdd_uv_test_i,      // Comparator: below lifted lower threshold.
  input  wire logic        vdd_below_3v5_i,    // Comparator: below 3.5 V.
  input  wire logic        output_enable_pin_i, // Enable pin level.
  output logic             output_enable_pin_o, // Enable pin drive value.
  output logic             output_enable_pin_oe_b_o, // Low while pulling the pin.
  output logic [15:0]      stage_on_o,         // Stage on commands, bit 0 is stage 1.
  output logic [7:0]       mon_rdata_o,        // Monitor register read value.
  output logic [7:0]       read_inputs_a_o,    // Input read word a.
  output logic [7:0]       read_inputs_b_o,    // Input read word b.
  output logic             fault_store_block_o // Diagnostics must not store faults.
);

  // Three-stage synchronisers for every pin input in the device domain.
  localparam int NSYNC = 25;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] pin_reg;

  assign pin_raw = {par_in_i, vdd_ov_i, vdd_ov_test_i, vdd_uv_i, vdd_uv_test_i,
                    vdd_below_3v5_i, output_enable_pin_i, frame_sync_strobe_i,
                    rst_b_i, 1'b0};

  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      pin_reg <= '0;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  logic [15:0] par_lvl;
  logic        ov_raw;
  logic        ov_test_raw;
  logic        uv_raw;
  logic        uv_test_raw;
  logic        low35;
  logic        en_pin_lvl;
  logic        sync_lvl;
  logic        rst_pin_lvl;

  assign par_lvl     = pin_reg[24:9];
  assign ov_raw      = pin_reg[8];
  assign ov_test_raw = pin_reg[7];
  assign uv_raw      = pin_reg[6];
  assign uv_test_raw = pin_reg[5];
  assign low35       = pin_reg[4];
  assign en_pin_lvl  = pin_reg[3];
  assign sync_lvl    = pin_reg[2];
  assign rst_pin_lvl = pin_reg[1];

  // Serial bus receiver on the frame clock. The sync pin clears the bit count
  // so that a stopped frame clock never needs an edge after the frame. The
  // external reset clears it too, so the very first frame is counted.
  logic [15:0]                  shift_reg;
  logic [`PSDC_FRAME_CNT_W-1:0] bit_cnt_reg;
  logic                         frame_clr;

  assign frame_clr = !rst_b_i || frame_sync_strobe_i;

  always_ff @(posedge frame_clock_in_i or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_reg <= '0;
    end else if (bit_cnt_reg != `PSDC_FRAME_CNT_W'(`PSDC_FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge frame_clock_in_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= `PSDC_HOLD_RESET;
    end else if (bit_cnt_reg != `PSDC_FRAME_CNT_W'(`PSDC_FRAME_BITS)) begin
      shift_reg <= {frame_data_in_i, shift_reg[15:1]};
    end
  end

  // The frame word is static once the frame clock stops before sync; the
  // sync edge acts as the request that the word is ready to cross.
  logic [15:0] word_s1_reg;
  logic [15:0] word_s2_reg;
  logic        sync_d_reg;
  logic [15:0] hold_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_s1_reg <= `PSDC_HOLD_RESET;
      word_s2_reg <= `PSDC_HOLD_RESET;
      sync_d_reg  <= 1'b0;
    end else begin
      word_s1_reg <= shift_reg;
      word_s2_reg <= word_s1_reg;
      sync_d_reg  <= sync_lvl;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_reg <= `PSDC_HOLD_RESET;
    end else if (sync_lvl && !sync_d_reg) begin
      hold_reg <= word_s2_reg;
    end
  end

  // Map holding bits to stages; 0 means on.
  logic [15:0] ubus_on;
  always_comb begin
    ubus_on                    = '0;
    ubus_on[13]                = ~hold_reg[0];
    ubus_on[6:0]               = ~hold_reg[7:1];
    ubus_on[10]                = ~hold_reg[9];
    ubus_on[9]                 = ~hold_reg[10];
    ubus_on[8]                 = ~hold_reg[11];
    ubus_on[11]                = ~hold_reg[12];
    ubus_on[12]                = ~hold_reg[13];
    ubus_on[15]                = ~hold_reg[14];
    ubus_on[14]                = ~hold_reg[15];
    ubus_on[`PSDC_STAGE8_IDX]  = 1'b0;
  end

  // Source selection; stage 8 keeps its selection through the external reset.
  logic [15:0] src_serial_reg;
  logic        bus_multiplex_select_reg;
  logic        src8_serial_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_serial_reg <= `PSDC_ALL_SERIAL;
      bus_multiplex_select_reg       <= 1'b1;
    end else begin
      src_serial_reg <= source_select_regs_i;
      bus_multiplex_select_reg       <= bus_multiplex_select_i;
    end
  end

  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      src8_serial_reg <= 1'b1;
    end else begin
      src8_serial_reg <= source_select_regs_i[`PSDC_STAGE8_IDX];
    end
  end

  // Monitor configuration bits.
  logic [2:0] mon_cfg_reg;
  logic       ov_stored_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mon_cfg_reg <= `PSDC_MON_CFG_RESET;
    end else if (mon_wr_i) begin
      mon_cfg_reg <= mon_wdata_i[`PSDC_MON_NORMAL_BIT:`PSDC_MON_LATCH_BIT];
    end
  end

  logic test_mode;
  logic uv_meas;
  logic ov_meas;

  assign test_mode = !mon_cfg_reg[2];
  assign ov_meas   = (test_mode && !mon_cfg_reg[1]) ? ov_test_raw : ov_raw;
  assign uv_meas   = (test_mode && mon_cfg_reg[1]) ? uv_test_raw : uv_raw;

  // Stored overvoltage; only the internal reset or latch-off clears it.
  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      ov_stored_reg <= 1'b0;
    end else if (ov_meas && mon_cfg_reg[0]) begin
      ov_stored_reg <= 1'b1;
    end else if (!mon_cfg_reg[0]) begin
      ov_stored_reg <= 1'b0;
    end
  end

  // Enable pin release after the supply recovers.
  psdc_mon_state_t               mon_state_reg;
  logic [`PSDC_FILT_W-1:0]       filt_cnt_reg;
  logic                          supply_bad;
  logic                          oe_b_reg;

  assign supply_bad = uv_meas || ov_meas || ov_stored_reg;

  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      mon_state_reg <= PSDC_MON_FAULT;
      filt_cnt_reg  <= '0;
      oe_b_reg      <= 1'b0;
    end else begin
      case (mon_state_reg)
        PSDC_MON_OK: begin
          if (supply_bad) begin
            mon_state_reg <= PSDC_MON_FAULT;
            oe_b_reg      <= 1'b0;
          end
        end
        PSDC_MON_FAULT: begin
          if (!supply_bad) begin
            mon_state_reg <= PSDC_MON_FILTER;
            filt_cnt_reg  <= '0;
          end
        end
        PSDC_MON_FILTER: begin
          if (supply_bad) begin
            mon_state_reg <= PSDC_MON_FAULT;
          end else if (filt_cnt_reg == `PSDC_FILT_W'(`PSDC_FILTER_CYC - 1)) begin
            mon_state_reg <= PSDC_MON_OK;
            oe_b_reg      <= 1'b1;
          end else begin
            filt_cnt_reg <= filt_cnt_reg + 1'b1;
          end
        end
        default: begin
          mon_state_reg <= PSDC_MON_FAULT;
          oe_b_reg      <= 1'b0;
        end
      endcase
    end
  end

  assign output_enable_pin_o      = 1'b0;
  assign output_enable_pin_oe_b_o = oe_b_reg;

  // Stage gating and source decode.
  logic [15:0] stage_next;
  logic        gate_ok;
  logic        gate_off;

  assign gate_ok  = en_pin_lvl && !uv_meas && !ov_meas;
  assign gate_off = !gate_ok;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!src_serial_reg[i]) begin
        stage_next[i] = par_lvl[i];
      end else if (!bus_multiplex_select_reg) begin
        stage_next[i] = ubus_on[i];
      end else begin
        stage_next[i] = spi_stage_on_i[i];
      end
      stage_next[i] = stage_next[i] && gate_ok && rst_pin_lvl;
    end
    if (src8_serial_reg) begin
      stage_next[`PSDC_STAGE8_IDX] = spi_stage_on_i[`PSDC_STAGE8_IDX] && gate_ok &&
                                     rst_pin_lvl;
    end else begin
      stage_next[`PSDC_STAGE8_IDX] = par_lvl[`PSDC_STAGE8_IDX] && !ov_meas &&
                                     !low35;
    end
  end

  logic [15:0] stage_reg;
  logic        stage8_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage_reg <= `PSDC_ALL_OFF;
    end else begin
      stage_reg <= stage_next;
    end
  end

  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      stage8_reg <= 1'b0;
    end else begin
      stage8_reg <= stage_next[`PSDC_STAGE8_IDX];
    end
  end

  always_comb begin
    stage_on_o                    = stage_reg;
    stage_on_o[`PSDC_STAGE8_IDX]  = stage8_reg;
  end

  // Read-back and diagnostic inhibit.
  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      mon_rdata_o         <= '0;
      read_inputs_a_o     <= '0;
      read_inputs_b_o     <= '0;
      fault_store_block_o <= 1'b1;
    end else begin
      mon_rdata_o     <= {mon_cfg_reg, 2'b00, en_pin_lvl, !uv_meas,
                          !(ov_meas || ov_stored_reg)};
      read_inputs_a_o <= {hold_reg[`PSDC_HOLD_TEST_BIT], par_lvl[6:0]};
      read_inputs_b_o <= par_lvl[15:8];
      fault_store_block_o <= gate_off;
    end
  end

endmodule

`default_nettype wire

// [tb/psdc_frame_src.sv]
`timescale 1ns/10ps
`default_nettype none
module psdc_frame_src (
  output logic fclk_o,  // Frame clock, idle low between frames.
  output logic fdata_o, // Frame data, D0 first.
  output logic fsync_o  // Sync strobe.
);
  initial begin
    fclk_o = 1'b0;
    fdata_o = 1'b0;
    fsync_o = 1'b0;
  end
  // Sends n bits of w at 8 MHz, then pulses sync once the clock has stopped.
  task automatic send(input logic [16:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      fdata_o = w[i];
      #62.5 fclk_o = 1'b1;
      #62.5 fclk_o = 1'b0;
    end
    fdata_o = ~fdata_o;
    #100 fsync_o = 1'b1;
    #100 fsync_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/psdc_top_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module psdc_top_chk (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        por_b_i,
  input wire logic [15:0] par_in_i,
  input wire logic [15:0] source_select_regs_i,
  input wire logic        mon_wr_i,
  input wire logic [7:0]  mon_wdata_i,
  input wire logic        vdd_ov_i,
  input wire logic        vdd_uv_i,
  input wire logic        output_enable_pin_i,
  input wire logic        output_enable_pin_oe_b_o,
  input wire logic [15:0] stage_on_o,
  input wire logic [7:0]  mon_rdata_o,
  input wire logic        fault_store_block_o
);
  logic [10:0] good_cnt_reg;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!por_b_i);
  // Counts cycles of good supply, saturating.
  always_ff @(posedge mclk_i or negedge por_b_i) begin
    if (!por_b_i) good_cnt_reg <= 11'h000;
    else if (vdd_uv_i || vdd_ov_i) good_cnt_reg <= 11'h000;
    else if (good_cnt_reg != 11'h7FF) good_cnt_reg <= good_cnt_reg + 11'h001;
  end
  rst_off_a: assert property (!rst_b_i |-> (stage_on_o & 16'hFF7F) == 16'h0000)
    else $error("stages on during reset");
  uv_pull_a: assert property (vdd_uv_i [*6] |-> !output_enable_pin_oe_b_o)
    else $error("enable not pulled on undervoltage");
  ov_flag_a: assert property (vdd_ov_i [*6] |-> !mon_rdata_o[0] && !output_enable_pin_oe_b_o)
    else $error("overvoltage not flagged");
  gate_off_a: assert property (fault_store_block_o [*2] |-> (stage_on_o & 16'hFF7F) == 16'h0000)
    else $error("stages on while gated");
  ext_low_a: assert property (!output_enable_pin_i [*6] |-> fault_store_block_o)
    else $error("external low not gating");
  filter_time_a: assert property ($rose(output_enable_pin_oe_b_o) |-> good_cnt_reg >= 11'h3E0)
    else $error("enable released before filter time");
  mon_cfg_a: assert property (mon_wr_i && rst_b_i ##1 !mon_wr_i && rst_b_i ##1 rst_b_i
    |-> mon_rdata_o[7:5] == $past(mon_wdata_i[7:5], 2))
    else $error("config bits not written");
  pin_read_a: assert property (output_enable_pin_i [*6] |-> mon_rdata_o[2] && mon_rdata_o[4:3] == 2'b00)
    else $error("pin level misread");
  par_follow_a: assert property ((rst_b_i && !fault_store_block_o && source_select_regs_i == 16'h0000
    && $stable(par_in_i)) [*6] |-> stage_on_o == par_in_i)
    else $error("stages not following pins");
endmodule
bind psdc_top psdc_top_chk i_psdc_top_chk (.mclk_i, .rst_b_i, .por_b_i, .par_in_i,
  .source_select_regs_i, .mon_wr_i, .mon_wdata_i, .vdd_ov_i, .vdd_uv_i, .output_enable_pin_i,
  .output_enable_pin_oe_b_o, .stage_on_o, .mon_rdata_o, .fault_store_block_o);
`default_nettype wire

// [tb/tb_psdc_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_psdc_top;
  logic        mclk_i, rst_b_i, por_b_i, mon_wr_i, bus_multiplex_select_i, ext_low;
  logic        vdd_ov_i, vdd_ov_test_i, vdd_uv_i, vdd_uv_test_i, vdd_below_3v5_i;
  logic [15:0] par_in_i, spi_stage_on_i, source_select_regs_i, stage_on_o;
  logic [7:0]  mon_wdata_i, mon_rdata_o, read_inputs_a_o, read_inputs_b_o;
  logic        output_enable_pin_o, output_enable_pin_oe_b_o, fault_store_block_o;
  wire logic   frame_clock_in_i, frame_data_in_i, frame_sync_strobe_i, output_enable_pin_i;
  int          error_cnt, checks_done;
  int          lane[16] = '{13, 0, 1, 2, 3, 4, 5, 6, 7, 10, 9, 8, 11, 12, 15, 14};
  assign output_enable_pin_i = (output_enable_pin_oe_b_o | output_enable_pin_o) & !ext_low;
  psdc_frame_src i_psdc_frame_src (.fclk_o(frame_clock_in_i), .fdata_o(frame_data_in_i),
    .fsync_o(frame_sync_strobe_i));
  psdc_top i_psdc_top (.mclk_i, .rst_b_i, .por_b_i, .frame_clock_in_i, .frame_data_in_i,
    .frame_sync_strobe_i, .par_in_i, .spi_stage_on_i, .source_select_regs_i,
    .bus_multiplex_select_i, .mon_wr_i, .mon_wdata_i, .vdd_ov_i, .vdd_ov_test_i, .vdd_uv_i,
    .vdd_uv_test_i, .vdd_below_3v5_i, .output_enable_pin_i, .output_enable_pin_o,
    .output_enable_pin_oe_b_o, .stage_on_o, .mon_rdata_o, .read_inputs_a_o, .read_inputs_b_o,
    .fault_store_block_o);
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    mon_wdata_i = d;
    mon_wr_i = 1'b1;
    step(1);
    mon_wr_i = 1'b0;
    step(8);
  endtask
  task automatic t_par;
    source_select_regs_i = 16'h0000;
    par_in_i = 16'h3C5A;
    step(8);
    chk("par stages", 16'h3C5A, stage_on_o);
    par_in_i = 16'h00FF;
    step(8);
    rst_b_i = 1'b0;
    step(4);
    chk("reset stages", 16'h0080, stage_on_o);
    rst_b_i = 1'b1;
    step(8);
  endtask
  task automatic t_bus;
    logic [15:0] w;
    logic [15:0] e;
    source_select_regs_i = 16'hFFFF;
    spi_stage_on_i = 16'h0000;
    bus_multiplex_select_i = 1'b0;
    par_in_i = 16'h5A3C;
    step(8);
    chk("bus reset", 16'h0000, stage_on_o);
    for (int k = 0; k < 16; k++) begin
      w = ~(16'h0001 << k);
      e = 16'h0000;
      if (k != 8) e[lane[k]] = 1'b1;
      i_psdc_frame_src.send({1'b0, w}, (k == 15) ? 17 : 16);
      step(10);
      chk("bus stages", e, stage_on_o);
      chk("test bit", {15'h0000, w[8]}, {15'h0000, read_inputs_a_o[7]});
    end
    chk("inputs", {1'b0, par_in_i[15:8], par_in_i[6:0]}, {1'b0, read_inputs_b_o, read_inputs_a_o[6:0]});
    bus_multiplex_select_i = 1'b1;
    source_select_regs_i = 16'h0000;
    par_in_i = 16'h0081;
  endtask
  task automatic t_uv;
    vdd_uv_i = 1'b1;
    step(8);
    chk("uv pin", 16'h0000, {15'h0000, output_enable_pin_oe_b_o});
    chk("uv stages", 16'h0080, stage_on_o);
    chk("uv flag", 16'h0000, {15'h0000, mon_rdata_o[1]});
    chk("uv block", 16'h0001, {15'h0000, fault_store_block_o});
    vdd_below_3v5_i = 1'b1;
    step(8);
    chk("low stage8", 16'h0000, stage_on_o);
    vdd_below_3v5_i = 1'b0;
    vdd_uv_i = 1'b0;
    step(900);
    chk("uv filter", 16'h0000, {15'h0000, output_enable_pin_oe_b_o});
    step(200);
    chk("uv release", 16'h0081, {output_enable_pin_oe_b_o ? stage_on_o : 16'h0000});
  endtask
  task automatic t_ov;
    vdd_ov_i = 1'b1;
    step(8);
    chk("ov stages", 16'h0000, stage_on_o);
    wr(8'hC0);
    wr(8'hE0);
    vdd_ov_i = 1'b0;
    step(1100);
    chk("ov latched", 16'h0000, {14'h0000, output_enable_pin_oe_b_o, mon_rdata_o[0]});
    rst_b_i = 1'b0;
    step(4);
    rst_b_i = 1'b1;
    step(8);
    chk("ov kept", 16'h0000, {15'h0000, mon_rdata_o[0]});
    wr(8'hC0);
    chk("ov cleared", 16'h0001, {15'h0000, mon_rdata_o[0]});
    wr(8'hE0);
    step(1100);
    chk("ov release", 16'h0001, {15'h0000, output_enable_pin_oe_b_o});
  endtask
  task automatic t_test;
    vdd_ov_test_i = 1'b1;
    wr(8'h00);
    chk("ov test", 16'h00E6, {8'h00, mon_rdata_o ^ 8'hE0});
    wr(8'hC0);
    vdd_ov_test_i = 1'b0;
    chk("ov test end", 16'h0001, {15'h0000, mon_rdata_o[0]});
    vdd_uv_test_i = 1'b1;
    wr(8'h40);
    chk("uv test", 16'h0000, {15'h0000, mon_rdata_o[1]});
    wr(8'hC0);
    vdd_uv_test_i = 1'b0;
    chk("uv test end", 16'h0001, {15'h0000, mon_rdata_o[1]});
    wr(8'hE0);
    step(1100);
    ext_low = 1'b1;
    step(8);
    chk("ext stages", 16'h0080, stage_on_o);
    chk("ext block", 16'h0001, {15'h0000, fault_store_block_o});
    ext_low = 1'b0;
    step(8);
    chk("ext back", 16'h0081, stage_on_o);
  endtask
  task automatic t_spi;
    step(1100);
    chk("spi stages", 16'hA5A5, stage_on_o);
    chk("monitor", 16'h00E7, {8'h00, mon_rdata_o});
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    {rst_b_i, por_b_i, mon_wr_i, ext_low, mon_wdata_i, par_in_i} = '0;
    {vdd_ov_i, vdd_ov_test_i, vdd_uv_i, vdd_uv_test_i, vdd_below_3v5_i} = '0;
    bus_multiplex_select_i = 1'b1;
    source_select_regs_i = 16'hFFFF;
    spi_stage_on_i = 16'hA5A5;
    step(16);
    {rst_b_i, por_b_i} = 2'b11;
    t_spi;
    t_par;
    t_bus;
    t_uv;
    t_ov;
    t_test;
    wrap_up;
  end
  initial begin
    #400000;
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
